// ===== verilog/monitor_gate_pkg.sv
// Purpose: Shared constants and types for the monitor security gate.
// Assumes: The bus clock and the system clock MCLK are the same clock.
// Notes:   Byte i of the stored code sits at bits [8*i+7:8*i], lowest address first.

// ************************************************************
// Package of constants and types
// ************************************************************
package monitor_gate_pkg;

   // Clock cycles per monitor bit.
   localparam int          BAUD_DIV     = 278;
   // Number of security bytes the host must send.
   localparam int          SEC_BYTES    = 8;
   // Address of the lowest and highest security locations.
   localparam logic [15:0] SEC_LO_ADDR  = 16'hFFF6;
   localparam logic [15:0] SEC_HI_ADDR  = 16'hFFFD;
   // RAM status byte address and its unlocked mask (bit 6).
   localparam logic [15:0] STATUS_ADDR  = 16'h0040;
   localparam logic [7:0]  UNLOCK_MASK  = 8'h40;
   // Value of an erased byte.
   localparam logic [7:0]  BLANK_BYTE   = 8'hFF;
   // Value returned for a protected read; the pattern is arbitrary.
   localparam logic [7:0]  INVALID_BYTE = 8'h00;
   // Default flash window; the bounds are arbitrary.
   localparam logic [15:0] FLASH_LO     = 16'h8000;
   localparam logic [15:0] FLASH_HI     = 16'hFFFF;
   // Bits sampled after the start bit: eight data and one stop or ninth.
   localparam int          RX_BITS      = 9;
   // Bits sent per character: start, eight data, two trailing bits.
   localparam int          TX_BITS      = 11;
   // Idle high bits driven before each echo or break reply.
   localparam int          PRE_BITS     = 2;
   // Tail patterns of an 11-bit frame, sent least significant bit first.
   localparam logic [1:0]  TAIL_CHAR    = 2'h3;
   localparam logic [1:0]  TAIL_BREAK   = 2'h2;
   localparam logic        START_BIT    = 1'h0;

   // Gate phase after power-on.
   typedef enum logic [1:0] {PH_ENTRY, PH_BREAK, PH_CMD} phase_t;
   // Receiver and transmitter states.
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS_ST, RX_WAIT} rx_state_t;
   typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_FRAME} tx_state_t;

   // A received character.
   typedef struct packed {
      logic       brk;
      logic [7:0] data;
   } rx_char_t;

   // A memory access request from the core.
   typedef struct packed {
      logic        fetch;
      logic [15:0] addr;
   } mem_req_t;

endpackage

// ===== verilog/monitor_security_gate.sv
// Purpose: Security gate on the monitor serial link and on flash accesses.
// Assumes: RST is the power-on reset; WARM_RST is any other reset, synchronous.
// Notes:   The serial pin is one wire; the receiver ignores it while we drive.
//
// How it works
// - Host's eight bytes compared to stored code.
// - After power-on, wait for eight bytes first.
// - Full match unlocks flash reads and fetches.
// - Unlock holds until the next power-on reset.
// - Other resets keep unlock and skip entry.
// - Mismatch still enters command mode.
// - Locked flash reads return invalid value.
// - Locked flash fetch raises illegal-address reset.
// - Entry break sent only after eighth byte.
// - Status byte bit 6 shows unlock.
// - Locked mass erase blanks stored code.
// - Received break answered by high, then break.
// - Frames are NRZ with equal bit rates.
// - Bit rate is clock divided by 278.
// - Every received byte is echoed back.

`timescale 1ns/1ps

module monitor_security_gate
   import monitor_gate_pkg::*;
#(
   parameter int          DIV      = BAUD_DIV,
   parameter logic [15:0] FLASH_LO_A = FLASH_LO,
   parameter logic [15:0] FLASH_HI_A = FLASH_HI
) (
   // Clock and resets.
   input  wire logic        MCLK,
   input  wire logic        RST,
   input  wire logic        WARM_RST,
   // Monitor serial pin, split into its three signals.
   input  wire logic        SER_IN,
   output logic             SER_OUT,
   output logic             SER_OE_N,
   // Stored security code and erase event from the flash array.
   input  wire logic [63:0] SEC_CODE,
   input  wire logic        MASS_ERASE,
   // Core memory access path.
   input  wire logic        MEM_REQ,
   input  wire mem_req_t    MEM_CMD,
   input  wire logic [7:0]  MEM_DATA_IN,
   output logic [7:0]       MEM_RDATA,
   output logic             MEM_ACK,
   output logic             ILLEGAL_RST,
   // Command stream to the monitor firmware.
   output logic             CMD_VALID,
   output rx_char_t         CMD_CHAR,
   // Gate status.
   output logic             READY,
   output logic             UNLOCKED,
   output logic [7:0]       STATUS_BYTE
);

   // ************************************************************
   // Declarations
   // ************************************************************
   localparam int CW = $clog2(DIV + 1);
   localparam logic [CW-1:0] DIV_LAST = CW'(DIV - 1);  // Full bit count.
   localparam logic [CW-1:0] DIV_HALF = CW'(DIV / 2);  // Mid-bit point.
   localparam logic [3:0]    RX_LAST  = 4'(RX_BITS - 1);
   localparam logic [3:0]    TX_LAST  = 4'(TX_BITS - 1);
   localparam logic [3:0]    PRE_LAST = 4'(PRE_BITS - 1);
   localparam logic [2:0]    IDX_LAST = 3'(SEC_BYTES - 1);

   phase_t          phase_r;     // Entry, break pending or command phase.
   logic [2:0]      idx_r;       // Index of the next security byte.
   logic            match_r;     // All bytes so far matched.
   logic            unlocked_r;  // Security bypassed.
   logic            erased_r;    // Stored code erased while locked.
   rx_state_t       rx_st_r;     // Receiver state.
   logic [CW-1:0]   rx_cnt_r;    // Receiver bit timer.
   logic [3:0]      rx_bit_r;    // Receiver bit number.
   logic [8:0]      rx_sh_r;     // Receiver shift register.
   tx_state_t       tx_st_r;     // Transmitter state.
   logic [CW-1:0]   tx_cnt_r;    // Transmitter bit timer.
   logic [3:0]      tx_bit_r;    // Transmitter bit number.
   logic [10:0]     tx_sh_r;     // Transmitter shift register.
   logic            tx_out_r;    // Registered pin level.
   logic            cmd_vld_r;   // Command character strobe.
   rx_char_t        cmd_chr_r;   // Last command character.
   logic [7:0]      rdata_r;     // Read data to the core.
   logic            ack_r;       // Access answered.
   logic            ill_r;       // Illegal-address reset pulse.

   // ************************************************************
   // Decode
   // ************************************************************
   wire         rx_tick  = (rx_cnt_r == '0);               // Bit timer expiry.
   wire         tx_tick  = (tx_cnt_r == '0);
   wire [8:0]   rx_sh_nxt = {SER_IN, rx_sh_r[8:1]};        // Next shift value.
   wire         rx_done  = (rx_st_r == RX_BITS_ST) && rx_tick && (rx_bit_r == RX_LAST);
   // A break is a start bit followed by nine low bits.
   wire         rx_brk   = (rx_sh_nxt == 9'h000);
   wire [7:0]   rx_byte  = rx_sh_nxt[7:0];
   wire         tx_idle  = (tx_st_r == TX_IDLE);
   // Stored byte in address order, blank once erased.
   wire [7:0]   sec_byte = erased_r ? BLANK_BYTE : SEC_CODE[{idx_r, 3'h0} +: 8];
   wire         byte_ok  = (rx_byte == sec_byte) && !rx_brk;
   wire         last_sec = (idx_r == IDX_LAST);
   // The break goes out only once the eighth echo has left.
   wire         brk_go   = (phase_r == PH_BREAK) && tx_idle;
   // Every received byte is echoed; a break is answered with a break.
   wire         echo_go  = rx_done && (phase_r != PH_BREAK);
   wire         tx_go    = echo_go || brk_go;
   wire         send_brk = brk_go || rx_brk;
   wire [10:0]  tx_word  = send_brk ? {TAIL_BREAK, 8'h00, START_BIT}
                                    : {TAIL_CHAR, rx_byte, START_BIT};
   wire         in_flash = (MEM_CMD.addr >= FLASH_LO_A) && (MEM_CMD.addr <= FLASH_HI_A);
   wire         locked   = !unlocked_r;
   // Accesses before the entry sequence finishes get no answer.
   wire         mem_take = MEM_REQ && (phase_r == PH_CMD);
   wire [7:0]   status_w = UNLOCK_MASK & {8{unlocked_r}};
   wire [7:0]   rdata_nxt = (MEM_CMD.addr == STATUS_ADDR) ? status_w :
                            (in_flash && locked)          ? INVALID_BYTE :
                                                            MEM_DATA_IN;

   // ************************************************************
   // Security state, cleared by power-on reset alone
   // ************************************************************
   // WARM_RST is not looked at here, so an unlock survives it.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         phase_r    <= PH_ENTRY;
         idx_r      <= '0;
         match_r    <= 1'h1;
         unlocked_r <= 1'h0;
         erased_r   <= 1'h0;
      end else begin
         // Erase only matters while locked; unlocked flash keeps its code view.
         if (MASS_ERASE && locked) begin
            erased_r <= 1'h1;
         end
         case (phase_r)
            PH_ENTRY: begin
               if (rx_done) begin
                  idx_r   <= idx_r + 3'h1;
                  match_r <= match_r && byte_ok;
                  if (last_sec) begin
                     unlocked_r <= match_r && byte_ok;
                     phase_r    <= PH_BREAK;
                  end
               end
            end
            PH_BREAK: begin
               // Command mode follows whether or not the code matched.
               if (brk_go) begin
                  phase_r <= PH_CMD;
               end
            end
            PH_CMD: begin
               phase_r <= PH_CMD;
            end
            default: begin
               phase_r <= PH_ENTRY;
            end
         endcase
      end
   end

   // ************************************************************
   // Receiver
   // ************************************************************
   // Samples mid-bit at the divided rate; ignores the pin while we drive.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         rx_st_r  <= RX_IDLE;
         rx_cnt_r <= '0;
         rx_bit_r <= '0;
         rx_sh_r  <= '0;
      end else if (WARM_RST) begin
         rx_st_r  <= RX_IDLE;
         rx_cnt_r <= '0;
         rx_bit_r <= '0;
      end else begin
         case (rx_st_r)
            RX_IDLE: begin
               // A falling edge on the idle line starts a character.
               if (!SER_IN && tx_idle) begin
                  rx_st_r  <= RX_START;
                  rx_cnt_r <= DIV_HALF;
               end
            end
            RX_START: begin
               if (!tx_idle) begin
                  rx_st_r <= RX_IDLE;
               end else if (rx_tick) begin
                  // A start bit gone high by mid-bit was a glitch.
                  rx_st_r  <= SER_IN ? RX_IDLE : RX_BITS_ST;
                  rx_cnt_r <= DIV_LAST;
                  rx_bit_r <= '0;
               end else begin
                  rx_cnt_r <= rx_cnt_r - CW'(1);
               end
            end
            RX_BITS_ST: begin
               if (rx_tick) begin
                  rx_sh_r  <= rx_sh_nxt;
                  rx_bit_r <= rx_bit_r + 4'h1;
                  rx_cnt_r <= DIV_LAST;
                  if (rx_bit_r == RX_LAST) begin
                     rx_st_r <= RX_WAIT;
                  end
               end else begin
                  rx_cnt_r <= rx_cnt_r - CW'(1);
               end
            end
            RX_WAIT: begin
               // A break holds the line low; wait for it to rise again.
               if (SER_IN) begin
                  rx_st_r <= RX_IDLE;
               end
            end
            default: begin
               rx_st_r <= RX_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Transmitter
   // ************************************************************
   // Two driven high bits, then an 11-bit frame, least significant first.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         tx_st_r  <= TX_IDLE;
         tx_cnt_r <= '0;
         tx_bit_r <= '0;
         tx_sh_r  <= '0;
         tx_out_r <= 1'h1;
      end else if (WARM_RST) begin
         tx_st_r  <= TX_IDLE;
         tx_out_r <= 1'h1;
      end else begin
         case (tx_st_r)
            TX_IDLE: begin
               tx_out_r <= 1'h1;
               if (tx_go) begin
                  tx_st_r  <= TX_PRE;
                  tx_sh_r  <= tx_word;
                  tx_cnt_r <= DIV_LAST;
                  tx_bit_r <= '0;
               end
            end
            TX_PRE: begin
               tx_out_r <= 1'h1;
               if (tx_tick) begin
                  tx_cnt_r <= DIV_LAST;
                  tx_bit_r <= tx_bit_r + 4'h1;
                  if (tx_bit_r == PRE_LAST) begin
                     tx_st_r  <= TX_FRAME;
                     tx_bit_r <= '0;
                     tx_out_r <= tx_sh_r[0];
                  end
               end else begin
                  tx_cnt_r <= tx_cnt_r - CW'(1);
               end
            end
            TX_FRAME: begin
               if (tx_tick) begin
                  tx_cnt_r <= DIV_LAST;
                  tx_bit_r <= tx_bit_r + 4'h1;
                  tx_sh_r  <= {1'h1, tx_sh_r[10:1]};
                  tx_out_r <= tx_sh_r[1];
                  if (tx_bit_r == TX_LAST) begin
                     tx_st_r  <= TX_IDLE;
                     tx_out_r <= 1'h1;
                  end
               end else begin
                  tx_cnt_r <= tx_cnt_r - CW'(1);
               end
            end
            default: begin
               tx_st_r <= TX_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Command stream and memory path
   // ************************************************************
   // Characters in command phase go to the firmware, locked or not.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         cmd_vld_r <= 1'h0;
         cmd_chr_r <= '0;
      end else begin
         cmd_vld_r <= rx_done && (phase_r == PH_CMD) && !WARM_RST;
         if (rx_done && (phase_r == PH_CMD)) begin
            cmd_chr_r <= '{brk: rx_brk, data: rx_byte};
         end
      end
   end

   // One cycle to answer; a locked flash fetch is turned into a reset pulse.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         rdata_r <= '0;
         ack_r   <= 1'h0;
         ill_r   <= 1'h0;
      end else begin
         ack_r <= mem_take;
         ill_r <= mem_take && MEM_CMD.fetch && in_flash && locked;
         if (mem_take) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign SER_OUT     = tx_out_r;
   assign SER_OE_N    = tx_idle;             // Low while driving the pin.
   assign MEM_RDATA   = rdata_r;
   assign MEM_ACK     = ack_r;
   assign ILLEGAL_RST = ill_r;
   assign CMD_VALID   = cmd_vld_r;
   assign CMD_CHAR    = cmd_chr_r;
   assign READY       = (phase_r == PH_CMD);
   assign UNLOCKED    = unlocked_r;
   assign STATUS_BYTE = status_w;

endmodule // monitor_security_gate

// ===== sim/monitor_gate_properties.sv
// Purpose: Concurrent checks on the ports of the monitor security gate.
// Assumes: RST is the power-on reset; DIV matches the bound instance.
// Notes:   Sees only the top module's ports; attached by bind below.
`timescale 1ns/1ps

module monitor_gate_properties
   import monitor_gate_pkg::*;
#(
   parameter int          DIV        = BAUD_DIV,
   parameter logic [15:0] FLASH_LO_A = FLASH_LO,
   parameter logic [15:0] FLASH_HI_A = FLASH_HI
) (
   // Clock, resets and serial pin.
   input wire logic        MCLK, RST, WARM_RST, SER_IN, SER_OUT, SER_OE_N,
   // Flash side and memory path.
   input wire logic [63:0] SEC_CODE,
   input wire logic        MASS_ERASE, MEM_REQ, MEM_ACK, ILLEGAL_RST,
   input wire mem_req_t    MEM_CMD,
   input wire logic [7:0]  MEM_DATA_IN, MEM_RDATA, STATUS_BYTE,
   // Command stream and status.
   input wire logic        CMD_VALID, READY, UNLOCKED,
   input wire rx_char_t    CMD_CHAR
);
   // *****
   // Helpers and properties
   // *****
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   logic [15:0] drv_r;  // Cycles the pin has been driven in a row.
   wire logic   in_fl = MEM_CMD.addr >= FLASH_LO_A && MEM_CMD.addr <= FLASH_HI_A;
   wire logic   acc   = MEM_REQ && READY;  // An accepted request.

   // Counting drive time lets one check cover the whole 13-bit reply.
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         drv_r <= 16'h0000;
      end else if (SER_OE_N) begin
         drv_r <= 16'h0000;
      end else begin
         drv_r <= drv_r + 16'h0001;
      end
   end

   property p_ack; acc |=> MEM_ACK; endproperty
   a_ack: assert property (p_ack) else $error("request not acknowledged");
   property p_refuse; MEM_REQ && !READY |=> !MEM_ACK; endproperty
   a_refuse: assert property (p_refuse) else $error("ack before entry done");
   property p_inval; acc && !UNLOCKED && in_fl && !MEM_CMD.fetch |=> MEM_RDATA == INVALID_BYTE;
   endproperty
   a_inval: assert property (p_inval) else $error("locked read leaked");
   property p_illeg; acc && !UNLOCKED && in_fl && MEM_CMD.fetch |=> ILLEGAL_RST; endproperty
   a_illeg: assert property (p_illeg) else $error("locked fetch not trapped");
   property p_open;
      acc && UNLOCKED && MEM_CMD.addr != STATUS_ADDR |=>
         !ILLEGAL_RST && MEM_RDATA == $past(MEM_DATA_IN);
   endproperty
   a_open: assert property (p_open) else $error("unlocked access blocked");
   property p_hold; UNLOCKED |=> UNLOCKED; endproperty
   a_hold: assert property (p_hold) else $error("unlock lost");
   property p_status; $stable(UNLOCKED) |-> STATUS_BYTE == (UNLOCKED ? UNLOCK_MASK : 8'h00);
   endproperty
   a_status: assert property (p_status) else $error("status byte wrong");
   property p_brk; $rose(READY) |-> ##[0:2] !SER_OE_N; endproperty
   a_brk: assert property (p_brk) else $error("ready without break");
   property p_frame; $rose(SER_OE_N) && !$past(WARM_RST) |-> drv_r == 13 * DIV; endproperty
   a_frame: assert property (p_frame) else $error("reply length wrong");
   property p_pre; $fell(SER_OE_N) |-> SER_OUT [*8]; endproperty
   a_pre: assert property (p_pre) else $error("reply not led by high");
   property p_idle; SER_OE_N |-> SER_OUT; endproperty
   a_idle: assert property (p_idle) else $error("idle pin not high");
   c_unl: cover property ($rose(UNLOCKED));
   c_ill: cover property (ILLEGAL_RST);
   c_brk: cover property (CMD_VALID && CMD_CHAR.brk);
endmodule // monitor_gate_properties

bind monitor_security_gate monitor_gate_properties #(
   .DIV(DIV), .FLASH_LO_A(FLASH_LO_A), .FLASH_HI_A(FLASH_HI_A)) chk_u (.*);

// ===== sim/host_link_model.sv
// Purpose: Host computer on the single-wire monitor serial link.
// Assumes: The wire idles high through a pull-up.
// Notes:   Sends bytes or breaks and decodes every 11-bit device reply.
`timescale 1ns/1ps

module host_link_model #(
   parameter int DIV = 8
) (
   input  wire logic        clk,
   input  wire logic        oe_n,
   input  wire logic        dev_out,
   output wire logic        line,
   output logic             rep_stb,
   output logic [10:0]      rep_frame
);
   logic        host_lvl = 1'b1;  // Host drive; high is also the pull-up level.
   logic [10:0] f;                // Reply being collected.

   // Device wins the wire while it drives; otherwise the host level shows.
   assign line = (oe_n === 1'b0) ? dev_out : host_lvl;

   // Sample each reply bit mid-bit after the two leading high bits.
   // One process owns the reply outputs, so they have a single driver.
   initial begin
      rep_stb = 1'b0;
      rep_frame = 11'h000;
      forever begin
         @(negedge oe_n);
         repeat (2 * DIV + DIV / 2) @(posedge clk);
         for (int i = 0; i < 11; i++) begin
            f[i] = line;
            if (i < 10) repeat (DIV) @(posedge clk);
         end
         rep_frame <= f;
         rep_stb <= 1'b1;
         @(posedge clk);
         rep_stb <= 1'b0;
      end
   end

   // One NRZ character, or a break of ten low bits, then wait out the reply.
   task automatic send(input logic [7:0] d, input logic brk, output logic ok);
      logic [9:0] bits;
      logic       seen;
      int         k;
      bits = brk ? 10'h000 : {1'b1, d, 1'b0};
      seen = 1'b0;
      for (k = 0; k < 40 * DIV && !oe_n; k++) @(negedge clk);
      @(negedge clk);
      for (k = 0; k < 10; k++) begin
         host_lvl = bits[k];
         repeat (DIV) @(negedge clk);
      end
      host_lvl = 1'b1;
      for (k = 0; k < 30 * DIV && !(seen && oe_n); k++) begin
         @(negedge clk);
         if (!oe_n) seen = 1'b1;
      end
      ok = seen && oe_n;
      repeat (DIV) @(negedge clk);  // One idle bit before the next byte.
   endtask
endmodule // host_link_model

// ===== sim/tb_monitor_security_gate.sv
// Purpose: Self-checking bench for the monitor security gate.
// Assumes: A short bit time DIV stands in for the long divisor.
// Notes:   Drivers queue expectations; one watcher compares results.
`timescale 1ns/1ps

module tb_monitor_security_gate;
   import monitor_gate_pkg::*;
   // *****
   // Stimulus, model and checks
   // *****
   localparam int D = 8;  // Bit time in cycles, kept short for run time.
   localparam logic [15:0] ADDRS [5] = '{STATUS_ADDR, SEC_HI_ADDR, 16'hC000, 16'h1000, SEC_LO_ADDR};
   localparam logic [4:0]  FETCH = 5'h0C;  // Entries 2 and 3 are fetches.
   logic        MCLK = 1'b0, RST = 1'b1, WARM_RST = 1'b0, MASS_ERASE = 1'b0, MEM_REQ = 1'b0;
   logic [63:0] SEC_CODE = 64'h0;
   mem_req_t    MEM_CMD = '0;
   logic [7:0]  MEM_DATA_IN = 8'h00;
   wire logic   ser_out, oe_n, line, rep_stb, mem_ack, ill, cmd_valid, ready, unl;
   wire logic [10:0] rep_frame;
   wire logic [7:0]  rdata, status;
   wire rx_char_t    cmd_char;
   logic [15:0] qf[$], qm[$], qc[$];  // Expected frames, memory answers, commands.
   int          err_total = 0, total_checks = 0, seed = 46619;
   logic        blank = 1'b0;  // Host sends erased bytes instead of the stored code.

   always #12.5 MCLK = ~MCLK;

   monitor_security_gate #(.DIV(D)) dut_u (.MCLK(MCLK), .RST(RST), .WARM_RST(WARM_RST),
      .SER_IN(line), .SER_OUT(ser_out), .SER_OE_N(oe_n), .SEC_CODE(SEC_CODE),
      .MASS_ERASE(MASS_ERASE), .MEM_REQ(MEM_REQ), .MEM_CMD(MEM_CMD),
      .MEM_DATA_IN(MEM_DATA_IN), .MEM_RDATA(rdata), .MEM_ACK(mem_ack), .ILLEGAL_RST(ill),
      .CMD_VALID(cmd_valid), .CMD_CHAR(cmd_char), .READY(ready), .UNLOCKED(unl),
      .STATUS_BYTE(status));
   host_link_model #(.DIV(D)) host_u (.clk(MCLK), .oe_n(oe_n), .dev_out(ser_out),
      .line(line), .rep_stb(rep_stb), .rep_frame(rep_frame));

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic end_of_test();
      if (err_total == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // A wait that ran out counts as a mismatch and ends the run.
   task automatic fail(input string n);
      chk(n, 16'h0001, 16'h0000);
      end_of_test();
   endtask

   // Back-to-back memory requests; expectations only when they will be taken.
   task automatic mem_all(input logic u, input logic r);
      logic fl;
      for (int i = 0; i < 5; i++) begin
         @(negedge MCLK);
         MEM_CMD = '{FETCH[i], ADDRS[i]};
         MEM_DATA_IN = 8'($random(seed));
         MEM_REQ = 1'b1;
         fl = ADDRS[i] >= FLASH_LO && ADDRS[i] <= FLASH_HI;
         if (r) qm.push_back({7'h00, FETCH[i] && fl && !u, ADDRS[i] == STATUS_ADDR ?
            (u ? UNLOCK_MASK : 8'h00) : (fl && !u ? INVALID_BYTE : MEM_DATA_IN)});
      end
      @(negedge MCLK);
      MEM_REQ = 1'b0;
      repeat (2) @(negedge MCLK);
   endtask

   // One character or break over the wire, with its echo and command noted.
   task automatic ser(input logic [7:0] d, input logic b, input logic cmd);
      logic ok;
      qf.push_back(b ? 16'h0400 : {5'h00, 2'h3, d, 1'b0});
      if (cmd) qc.push_back({7'h00, b, b ? 8'h00 : d});
      host_u.send(d, b, ok);
      if (!ok) fail("echo");
   endtask

   // Eight entry bytes; byte number bad is corrupted, none if bad is 8.
   task automatic entry(input int bad);
      logic [7:0] sb;  // Byte the host sends before any corruption.
      for (int i = 0; i < SEC_BYTES; i++) begin
         if (i == SEC_BYTES - 1) chk("early_ready", 16'h0000, {15'h0, ready});
         sb = blank ? BLANK_BYTE : SEC_CODE[8*i +: 8];
         ser(sb ^ (i == bad ? 8'h10 : 8'h00), 1'b0, 1'b0);
      end
      qf.push_back(16'h0400);
      for (int k = 0; k < 40 * D && qf.size() > 0; k++) @(negedge MCLK);
      if (qf.size() > 0) fail("break");
      chk("ready", 16'h0001, {15'h0, ready});
      chk("unlocked", {15'h0, bad > 7}, {15'h0, unl});
      chk("status", {8'h00, bad > 7 ? UNLOCK_MASK : 8'h00}, {8'h00, status});
   endtask

   // Watcher: each result takes the oldest note of its kind.
   always @(negedge MCLK) begin
      if (rep_stb) chk("frame", qf.size() ? qf.pop_front() : 16'hFFFF, {5'h0, rep_frame});
      if (mem_ack) chk("mem", qm.size() ? qm.pop_front() : 16'hFFFF, {7'h0, ill, rdata});
      if (cmd_valid) chk("cmd", qc.size() ? qc.pop_front() : 16'hFFFF, {7'h0, cmd_char});
   end

   task automatic pulse(ref logic s);
      @(negedge MCLK);
      s = 1'b1;
      @(negedge MCLK);
      s = 1'b0;
   endtask

   initial begin
      SEC_CODE = {$random(seed), $random(seed)};  // Stands for non-blank programmed data.
      repeat (12) @(negedge MCLK);
      RST = 1'b0;
      mem_all(1'b0, 1'b0);
      entry(8);
      mem_all(1'b1, 1'b1);
      pulse(WARM_RST);
      chk("warm_unlocked", 16'h0001, {15'h0, unl});
      ser(8'($random(seed)), 1'b0, 1'b1);
      ser(8'h00, 1'b1, 1'b1);
      pulse(MASS_ERASE);
      mem_all(1'b1, 1'b1);
      pulse(RST);
      entry(int'($unsigned($random(seed)) % 8));
      mem_all(1'b0, 1'b1);
      ser(8'h5A, 1'b0, 1'b1);
      pulse(MASS_ERASE);
      pulse(RST);
      // An erase while locked in entry must make blank bytes the code to match.
      pulse(MASS_ERASE);
      blank = 1'b1;
      entry(8);
      end_of_test();
   end

   // Cuts a hang short.
   initial begin
      repeat (100000) @(posedge MCLK);
      fail("timeout");
   end
endmodule // tb_monitor_security_gate
